// ### verif/pcsre_mac_model.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================
// Reconciliation layer sink
module pcsre_mac_model (
    input wire logic mclk, // Receive clock
    input wire logic rst_b, // Async reset, low
    input wire pcsre_pkg::pcsre_xgmii_type xgmii, // Decoded word
    input wire logic xgmii_valid, // Word strobe
    output pcsre_pkg::pcsre_xgmii_type rx_word, // Captured word
    output logic rx_stb // Capture strobe
);
    import pcsre_pkg::*;
    // Capture each word; the word is held so late sampling still sees it
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rx_stb <= 1'b0;
            rx_word <= '0;
        end else begin
            rx_stb <= xgmii_valid;
            if (xgmii_valid) begin
                rx_word <= xgmii;
            end
        end
    end
endmodule // pcsre_mac_model
`default_nettype wire

// ### verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================
// Stream bench
module tb;
    import pcsre_pkg::*;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic signal_detect = 1'b1;
    logic fec_en = 1'b0;
    logic fec_err_pass = 1'b0;
    logic blk_valid = 1'b0;
    logic buf_underflow = 1'b0;
    pcsre_blk_type blk = '0;
    pcsre_xgmii_type xgmii, rx_word;
    logic xgmii_valid, block_lock, rx_stb;
    pcsre_xgmii_type exp_q[$];
    int fails = 0;
    int checks = 0;
    logic [63:0] p;
    logic [7:0] term_t [8] = '{8'h87, 8'h99, 8'haa, 8'hb4, 8'hcc, 8'hd2, 8'he1, 8'hff};
    logic [7:0] bad_t [4] = '{8'h33, 8'h2d, 8'h66, 8'h55};
    localparam pcsre_xgmii_type LF = {64'h07070707_0100009c, 8'hf1};
    localparam pcsre_xgmii_type IDL = {{8{PCSRE_CH_IDLE}}, 8'hff};
    localparam pcsre_xgmii_type ERW = {{8{PCSRE_CH_ERR}}, 8'hff};
    localparam logic [63:0] IP = {56'h0, PCSRE_BT_IDLE};

    // Clock at 100 MHz
    always #5 mclk = ~mclk;

    pcsre_top #(.GOOD_CNT(4), .BAD_CNT(2), .LF_BLOCKS(2)) i_dut (
        .mclk(mclk), .rst_b(rst_b), .signal_detect(signal_detect), .fec_en(fec_en),
        .fec_err_pass(fec_err_pass), .blk_valid(blk_valid), .blk(blk),
        .buf_underflow(buf_underflow), .xgmii(xgmii), .xgmii_valid(xgmii_valid),
        .block_lock(block_lock));
    pcsre_mac_model i_mac (.mclk(mclk), .rst_b(rst_b), .xgmii(xgmii),
        .xgmii_valid(xgmii_valid), .rx_word(rx_word), .rx_stb(rx_stb));

    task automatic cmp_word(input pcsre_xgmii_type a, input pcsre_xgmii_type e);
        checks++;
        if (a !== e) begin
            fails++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e);
        end
    endtask

    task automatic cmp_bit(input logic a, input logic e);
        checks++;
        if (a !== e) begin
            fails++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e);
        end
    endtask

    // One block per edge; the note goes in the queue as it is sent
    task automatic send(input logic [1:0] h, input logic [63:0] d, input logic u,
                        input logic ck, input pcsre_xgmii_type e);
        @(posedge mclk);
        blk_valid <= 1'b1;
        blk <= {h, d, u};
        if (ck) begin
            exp_q.push_back(e);
        end
    endtask

    // Stop sending, wait for the notes to be used, bounded
    task automatic settle;
        int n;
        n = 0;
        @(posedge mclk);
        blk_valid <= 1'b0;
        while (exp_q.size() != 0 && n < 100) begin
            @(posedge mclk);
            n++;
        end
        if (n == 100) begin
            fails++;
        end
        repeat (6) @(posedge mclk);
    endtask

    function automatic pcsre_xgmii_type term_w(input int k, input logic [63:0] d);
        pcsre_xgmii_type r;
        for (int i = 0; i < 8; i++) begin
            r.d[8*i+:8] = (i < k) ? d[8*i+8+:8] : (i == k) ? PCSRE_CH_TERM : PCSRE_CH_IDLE;
            r.c[i] = (i >= k);
        end
        return r;
    endfunction

    task automatic tally_and_finish;
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Each received word against the oldest note
    always @(posedge mclk) begin
        if (rx_stb === 1'b1) begin
            // A word with no note waiting is a mismatch by itself
            cmp_word(rx_word, (exp_q.size() != 0) ? exp_q.pop_front() : ~rx_word);
        end
    end

    // Watchdog: the tests need well under 2000 cycles
    initial begin
        #50000;
        fails++;
        tally_and_finish();
    end

    // =====================================================
    // Main sequence
    initial begin
        void'($urandom(32'h93c1));
        repeat (4) @(posedge mclk);
        cmp_word(xgmii, LF);
        rst_b <= 1'b1;
        repeat (5) @(posedge mclk);
        // Four headers to lock: the first four words are still faults
        repeat (4) send(PCSRE_HDR_CTRL, IP, 1'b0, 1'b1, LF);
        repeat (6) send(PCSRE_HDR_CTRL, IP, 1'b0, 1'b1, IDL);
        settle();
        cmp_bit(block_lock, 1'b1);
        $display("test lock done");
        for (int k = 0; k < 8; k++) begin
            p = {$urandom, $urandom};
            send(PCSRE_HDR_CTRL, {p[63:8], PCSRE_BT_START}, 1'b0, 1'b1,
                 {p[63:8], PCSRE_CH_START, 8'h01});
            send(PCSRE_HDR_DATA, ~p, 1'b0, 1'b1, {~p, 8'h00});
            send(PCSRE_HDR_CTRL, {p[63:8], term_t[k]}, 1'b0, 1'b1,
                 term_w(k, {p[63:8], term_t[k]}));
        end
        send(PCSRE_HDR_DATA, p, 1'b0, 1'b1, ERW);
        send(PCSRE_HDR_CTRL, IP, 1'b0, 1'b1, IDL);
        send(PCSRE_HDR_DATA, p, 1'b0, 1'b1, ERW);
        send(PCSRE_HDR_CTRL, {p[63:8], PCSRE_BT_START}, 1'b0, 1'b1,
             {p[63:8], PCSRE_CH_START, 8'h01});
        send(PCSRE_HDR_CTRL, {p[63:8], PCSRE_BT_START}, 1'b0, 1'b1, ERW);
        send(PCSRE_HDR_CTRL, IP, 1'b0, 1'b1, IDL);
        // Idle inside a frame is out of order as well
        send(PCSRE_HDR_CTRL, {p[63:8], PCSRE_BT_START}, 1'b0, 1'b1,
             {p[63:8], PCSRE_CH_START, 8'h01});
        send(PCSRE_HDR_CTRL, IP, 1'b0, 1'b1, ERW);
        send(PCSRE_HDR_CTRL, IP, 1'b0, 1'b1, IDL);
        settle();
        $display("test order done");
        for (int h = 0; h < 2; h++) begin
            send({2{h[0]}}, IP, 1'b0, 1'b1, ERW);
            send(PCSRE_HDR_CTRL, IP, 1'b0, 1'b1, IDL);
        end
        for (int t = 0; t < 4; t++) begin
            send(PCSRE_HDR_CTRL, {56'h0, bad_t[t]}, 1'b0, 1'b1, ERW);
            send(PCSRE_HDR_CTRL, IP, 1'b0, 1'b1, IDL);
        end
        settle();
        cmp_bit(block_lock, 1'b1);
        $display("test bad block done");
        for (int m = 0; m < 4; m++) begin
            @(posedge mclk);
            fec_en <= m[0];
            fec_err_pass <= m[1];
            send(PCSRE_HDR_CTRL, IP, 1'b1, 1'b1, (m == 3) ? ERW : IDL);
            send(PCSRE_HDR_CTRL, IP, 1'b0, 1'b1, IDL);
            settle();
        end
        $display("test fec done");
        @(posedge mclk);
        buf_underflow <= 1'b1;
        @(posedge mclk);
        buf_underflow <= 1'b0;
        send(PCSRE_HDR_CTRL, IP, 1'b0, 1'b1, ERW);
        send(PCSRE_HDR_CTRL, IP, 1'b0, 1'b1, LF);
        send(PCSRE_HDR_CTRL, IP, 1'b0, 1'b1, LF);
        send(PCSRE_HDR_CTRL, IP, 1'b0, 1'b1, IDL);
        settle();
        $display("test underflow done");
        @(posedge mclk);
        signal_detect <= 1'b0;
        // Two sync stages, the lock state, then the registered output
        repeat (5) @(posedge mclk);
        cmp_bit(block_lock, 1'b0);
        repeat (6) send(PCSRE_HDR_CTRL, IP, 1'b0, 1'b1, LF);
        settle();
        cmp_bit(block_lock, 1'b0);
        $display("test signal loss done");
        tally_and_finish();
    end
endmodule // tb
`default_nettype wire

// ### verilog/pcsre_pkg_fec.sv
// =====================================================
// Shared constants and carriers
package pcsre_pkg;
    localparam logic [1:0] PCSRE_HDR_DATA = 2'b10;
    localparam logic [1:0] PCSRE_HDR_CTRL = 2'b01;
    localparam logic [1:0] PCSRE_HDR_BAD = 2'b00;
    localparam logic [7:0] PCSRE_BT_IDLE = 8'h1e;
    localparam logic [7:0] PCSRE_BT_ORDSET = 8'h4b;
    localparam logic [7:0] PCSRE_BT_START = 8'h78;
    localparam logic [7:0] PCSRE_CH_IDLE = 8'h07;
    localparam logic [7:0] PCSRE_CH_ERR = 8'hfe;
    localparam logic [7:0] PCSRE_CH_START = 8'hfb;
    localparam logic [7:0] PCSRE_CH_TERM = 8'hfd;
    localparam logic [7:0] PCSRE_CH_SEQ = 8'h9c;
    localparam logic [7:0] PCSRE_LF_LANE3 = 8'h01;
    localparam int PCSRE_LOCK_GOOD = 64;
    localparam int PCSRE_LOCK_BAD = 16;
    localparam int PCSRE_LF_BLOCKS = 4;
    typedef struct packed {
        logic [1:0] hdr;
        logic [63:0] pay;
        logic uncorr;
    } pcsre_blk_type;
    typedef struct packed {
        logic [63:0] d;
        logic [7:0] c;
    } pcsre_xgmii_type;
endpackage

`timescale 1ns/1ps
`default_nettype none
// =====================================================
// FEC error passing stage
module pcsre_fec_pass (
    input wire logic mclk, // Receive clock
    input wire logic rst_n, // Synchronised reset
    input wire logic in_valid, // Block strobe
    input wire pcsre_pkg::pcsre_blk_type in_blk, // Block from FEC
    input wire logic fec_en, // FEC enabled
    input wire logic err_pass, // Error passing enabled
    output logic out_valid, // Registered strobe
    output pcsre_pkg::pcsre_blk_type out_blk // Registered block
);
    import pcsre_pkg::*;

    // One register stage; header overwritten when marked
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            out_valid <= 1'b0;
            out_blk <= '0;
        end else begin
            out_valid <= in_valid;
            out_blk <= in_blk;
            if (fec_en && err_pass && in_blk.uncorr) begin
                out_blk.hdr <= PCSRE_HDR_BAD;
            end
        end
    end

    property p_fec_force;
        @(posedge mclk) disable iff (!rst_n)
        (in_valid && fec_en && err_pass && in_blk.uncorr)
            |=> (out_valid && out_blk.hdr[1] == out_blk.hdr[0]);
    endproperty
    a_fec_force: assert property (p_fec_force) else $error("fec header not forced");
    c_fec_force: cover property (p_fec_force);
endmodule // pcsre_fec_pass
`default_nettype wire

// ### verilog/pcsre_top.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================
// Receive decoder with error block insertion
module pcsre_top #(
    parameter int GOOD_CNT = pcsre_pkg::PCSRE_LOCK_GOOD, // Headers to lock
    parameter int BAD_CNT = pcsre_pkg::PCSRE_LOCK_BAD, // Bad headers to unlock
    parameter int LF_BLOCKS = pcsre_pkg::PCSRE_LF_BLOCKS // Faults after underflow
) (
    input wire logic mclk, // Receive clock 100 MHz
    input wire logic rst_b, // Async reset, low
    input wire logic signal_detect, // Optical signal pin
    input wire logic fec_en, // FEC enable bit
    input wire logic fec_err_pass, // FEC error passing bit
    input wire logic blk_valid, // Block strobe
    input wire pcsre_pkg::pcsre_blk_type blk, // 66-bit block plus uncorrectable flag
    input wire logic buf_underflow, // Elastic buffer underflow
    output pcsre_pkg::pcsre_xgmii_type xgmii, // Decoded word
    output logic xgmii_valid, // Word strobe
    output logic block_lock // Sync achieved
);
    import pcsre_pkg::*;

    typedef enum {ST_INIT, ST_C, ST_D, ST_T, ST_E} pcsre_rx_type;
    typedef enum {CL_C, CL_S, CL_D, CL_T, CL_E} pcsre_cls_type;
    typedef enum {SY_LOSS, SY_LOCK} pcsre_sync_type;

    logic rst_m_q, rst_n;
    logic sd_m_q, sd_s_q;
    logic fv;
    pcsre_blk_type fb;
    pcsre_rx_type st_q, ns;
    pcsre_cls_type cls;
    pcsre_sync_type sync_q;
    logic [6:0] good_q;
    logic [4:0] bad_q;
    logic uf_pend_q;
    logic [3:0] uf_cnt_q;
    pcsre_xgmii_type dec;

    // =====================================================
    // Reset and pin synchronisers
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rst_m_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_m_q <= 1'b1;
            rst_n <= rst_m_q;
        end
    end

    // Pin is asynchronous, two stages before use
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sd_m_q <= 1'b0;
            sd_s_q <= 1'b0;
        end else begin
            sd_m_q <= signal_detect;
            sd_s_q <= sd_m_q;
        end
    end

    // FEC error passing ahead of the decoder
    pcsre_fec_pass u_fec (
        .mclk(mclk),
        .rst_n(rst_n),
        .in_valid(blk_valid),
        .in_blk(blk),
        .fec_en(fec_en),
        .err_pass(fec_err_pass),
        .out_valid(fv),
        .out_blk(fb)
    );

    // =====================================================
    // Block lock
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sync_q <= SY_LOSS;
            good_q <= '0;
            bad_q <= '0;
        end else if (!sd_s_q) begin
            sync_q <= SY_LOSS;
            good_q <= '0;
            bad_q <= '0;
        end else if (fv) begin
            // Headers 00 and 11 count as invalid
            if (fb.hdr[1] ^ fb.hdr[0]) begin
                bad_q <= '0;
                if (sync_q == SY_LOSS) begin
                    good_q <= good_q + 7'd1;
                    if (good_q == 7'(GOOD_CNT - 1)) begin
                        sync_q <= SY_LOCK;
                    end
                end
            end else begin
                good_q <= '0;
                if (sync_q == SY_LOCK) begin
                    bad_q <= bad_q + 5'd1;
                    if (bad_q == 5'(BAD_CNT - 1)) begin
                        sync_q <= SY_LOSS;
                    end
                end
            end
        end
    end

    // =====================================================
    // Classification and translation
    function automatic int term_lanes(input logic [7:0] bt);
        unique case (bt)
            8'h87: term_lanes = 0;
            8'h99: term_lanes = 1;
            8'haa: term_lanes = 2;
            8'hb4: term_lanes = 3;
            8'hcc: term_lanes = 4;
            8'hd2: term_lanes = 5;
            8'he1: term_lanes = 6;
            8'hff: term_lanes = 7;
            default: term_lanes = -1;
        endcase
    endfunction

    always_comb begin
        int k;
        logic [63:0] tdat;
        k = term_lanes(fb.pay[7:0]);
        // Data lanes shifted down so no select runs past bit 63
        tdat = {8'h00, fb.pay[63:8]};
        dec.d = {8{PCSRE_CH_IDLE}};
        dec.c = 8'hff;
        cls = CL_E;
        // bad header is an error block
        if (fb.hdr == PCSRE_HDR_DATA) begin
            cls = CL_D;
            dec.d = fb.pay;
            dec.c = 8'h00;
        end else if (fb.hdr == PCSRE_HDR_CTRL) begin
            // unknown type is an error block
            if (fb.pay[7:0] == PCSRE_BT_IDLE) begin
                cls = CL_C;
            end else if (fb.pay[7:0] == PCSRE_BT_ORDSET) begin
                cls = CL_C;
                dec.d[31:0] = {fb.pay[31:8], PCSRE_CH_SEQ};
                dec.c[3:0] = 4'h1;
            end else if (fb.pay[7:0] == PCSRE_BT_START) begin
                cls = CL_S;
                dec.d = {fb.pay[63:8], PCSRE_CH_START};
                dec.c = 8'h01;
            end else if (k >= 0) begin
                cls = CL_T;
                for (int i = 0; i < 8; i++) begin
                    if (i < k) begin
                        dec.d[8*i +: 8] = tdat[8*i +: 8];
                        dec.c[i] = 1'b0;
                    end else if (i == k) begin
                        dec.d[8*i +: 8] = PCSRE_CH_TERM;
                    end
                end
            end
        end
    end

    // Fault and error words; constants so the reset branch stays constant
    // local fault sequence in lane0
    localparam pcsre_xgmii_type LF_WORD = '{
        d: {{4{PCSRE_CH_IDLE}}, PCSRE_LF_LANE3, 16'h0000, PCSRE_CH_SEQ},
        c: 8'hf1
    };
    localparam pcsre_xgmii_type ERR_WORD = '{d: {8{PCSRE_CH_ERR}}, c: 8'hff};

    // =====================================================
    // Receive sequencing
    always_comb begin
        ns = ST_E;
        unique case (st_q)
            ST_INIT, ST_C, ST_T: begin
                if (cls == CL_C) ns = ST_C;
                else if (cls == CL_S) ns = ST_D;
            end
            ST_D: begin
                if (cls == CL_D) ns = ST_D;
                else if (cls == CL_T) ns = ST_T;
            end
            ST_E: begin
                if (cls == CL_C) ns = ST_C;
                else if (cls == CL_S || cls == CL_D) ns = ST_D;
                else if (cls == CL_T) ns = ST_T;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= ST_INIT;
        end else if (fv) begin
            st_q <= (sync_q == SY_LOCK) ? ns : ST_INIT;
        end
    end

    // Underflow bookkeeping; a new underflow beats the clear
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            uf_pend_q <= 1'b0;
            uf_cnt_q <= '0;
        end else begin
            if (fv && uf_pend_q) begin
                uf_cnt_q <= 4'(LF_BLOCKS);
            end else if (fv && uf_cnt_q != 4'h0) begin
                uf_cnt_q <= uf_cnt_q - 4'h1;
            end
            if (buf_underflow) begin
                uf_pend_q <= 1'b1;
            end else if (fv) begin
                uf_pend_q <= 1'b0;
            end
        end
    end

    // =====================================================
    // Output word; loss of sync outranks underflow
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            xgmii <= LF_WORD;
            xgmii_valid <= 1'b0;
            block_lock <= 1'b0;
        end else begin
            xgmii_valid <= fv;
            block_lock <= (sync_q == SY_LOCK);
            if (fv) begin
                if (sync_q == SY_LOSS) begin
                    xgmii <= LF_WORD;
                end else if (uf_pend_q) begin
                    xgmii <= ERR_WORD;
                end else if (uf_cnt_q != 4'h0) begin
                    xgmii <= LF_WORD;
                end else if (ns == ST_E) begin
                    xgmii <= ERR_WORD;
                end else begin
                    xgmii <= dec;
                end
            end
        end
    end

    // =====================================================
    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_err_out;
        (fv && sync_q == SY_LOCK && !uf_pend_q && uf_cnt_q == 4'h0 && ns == ST_E)
            |=> (xgmii.d == {8{PCSRE_CH_ERR}} && xgmii.c == 8'hff && xgmii_valid);
    endproperty
    a_err_out: assert property (p_err_out) else $error("error block not emitted");

    property p_order;
        (fv && sync_q == SY_LOCK && st_q == ST_D && cls == CL_C) |=> st_q == ST_E;
    endproperty
    a_order: assert property (p_order) else $error("out of order not caught");

    property p_bad_hdr;
        (fv && sync_q == SY_LOCK && fb.hdr[1] == fb.hdr[0]) |=> st_q == ST_E;
    endproperty
    a_bad_hdr: assert property (p_bad_hdr) else $error("bad header not error");

    property p_bad_type;
        (fv && sync_q == SY_LOCK && fb.hdr == PCSRE_HDR_CTRL && cls == CL_E && uf_cnt_q == 4'h0)
            |=> (st_q == ST_E && xgmii.d == {8{PCSRE_CH_ERR}} && xgmii.c == 8'hff);
    endproperty
    a_bad_type: assert property (p_bad_type) else $error("bad type not error");

    property p_uf_seq;
        (fv && uf_pend_q && sync_q == SY_LOCK)
            |=> (xgmii.d == {8{PCSRE_CH_ERR}}) ##0 (uf_cnt_q == 4'(LF_BLOCKS));
    endproperty
    a_uf_seq: assert property (p_uf_seq) else $error("underflow error missing");

    property p_sd_loss;
        !sd_s_q |=> (sync_q == SY_LOSS) [*2];
    endproperty
    a_sd_loss: assert property (p_sd_loss) else $error("sync held without signal");

    property p_lf_word;
        (fv && (sync_q == SY_LOSS || (!uf_pend_q && uf_cnt_q != 4'h0)))
            |=> (xgmii.d[7:0] == PCSRE_CH_SEQ && xgmii.c[0]);
    endproperty
    a_lf_word: assert property (p_lf_word) else $error("local fault malformed");

    property p_err_lanes;
        (xgmii_valid && xgmii.d[7:0] == PCSRE_CH_ERR && xgmii.c[0])
            |-> (xgmii.d == {8{PCSRE_CH_ERR}} && xgmii.c == 8'hff);
    endproperty
    a_err_lanes: assert property (p_err_lanes) else $error("partial error block");

    c_lock: cover property ($rose(block_lock));
    c_frame: cover property (st_q == ST_D ##[1:20] st_q == ST_T);
    c_uf: cover property (p_uf_seq);
    c_err: cover property (st_q == ST_E);
endmodule // pcsre_top
`default_nettype wire
